// >>> pkg/mcycle_if.sv
`timescale 1ns/1ps
interface mcycle_if;
   logic tick;
   logic [1:0] count_fall;

   modport gen (output tick);
   modport sampler (input tick, output count_fall);
   modport core (input tick, input count_fall);
endinterface

// >>> pkg/timer_pkg.sv
package timer_pkg;

   // Register offsets on the plain register port.
   localparam logic [2:0] OFS_CONTROL = 3'h0;
   localparam logic [2:0] OFS_MODE = 3'h1;
   localparam logic [2:0] OFS_LOW_T0 = 3'h2;
   localparam logic [2:0] OFS_HIGH_T0 = 3'h3;
   localparam logic [2:0] OFS_LOW_T1 = 3'h4;
   localparam logic [2:0] OFS_HIGH_T1 = 3'h5;

   // Control register fields.
   localparam int CTL_RUN_T0 = 4;
   localparam int CTL_FLAG_T0 = 5;
   localparam int CTL_RUN_T1 = 6;
   localparam int CTL_FLAG_T1 = 7;

   // Mode register fields: timer 0 in the low nibble, timer 1 in the high.
   localparam int MOD_SEL_T0 = 0;
   localparam int MOD_CT_T0 = 2;
   localparam int MOD_GATE_T0 = 3;
   localparam int MOD_SEL_T1 = 4;
   localparam int MOD_CT_T1 = 6;
   localparam int MOD_GATE_T1 = 7;

   // Reset values.
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // Prescaler width used by the 13-bit mode.
   localparam int PRESCALE_BITS = 5;
   localparam logic [4:0] PRESCALE_MAX = 5'h1f;

   // Machine cycle: twelve oscillator periods, one oscillator period per
   // reference clock period.
   localparam real CLK_PERIOD_NS = 4.0;
   localparam real MCYCLE_NS = 12.0 * CLK_PERIOD_NS;
   localparam int MCYCLE_CLKS = int'(MCYCLE_NS / CLK_PERIOD_NS);
   localparam logic [3:0] MCYCLE_LAST = 4'(MCYCLE_CLKS - 1);

   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD,
      MODE_SPLIT
   } timer_mode_t;

endpackage

// >>> rtl/dual_timer.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module dual_timer
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // External pins.
   input wire logic count_pin_t0_in,
   input wire logic count_pin_t1_in,
   input wire logic gate_pin_t0_in,
   input wire logic gate_pin_t1_in,
   // Interrupt vectoring acknowledges.
   input wire logic vector_ack_t0_in,
   input wire logic vector_ack_t1_in,
   // Overflow flags and timer 1's overflow event pulse.
   output logic overflow_flag_t0_out,
   output logic overflow_flag_t1_out,
   output logic overflow_pulse_t1_out
);

   mcycle_if mc ();

   mcycle_gen u_gen (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .mc(mc)
   );

   pin_sampler u_sampler (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .count_pin_in({count_pin_t1_in, count_pin_t0_in}),
      .mc(mc)
   );

   logic run_bit_t0;
   logic run_bit_t1;
   logic overflow_flag_t0;
   logic overflow_flag_t1;
   logic [7:0] timer_mode_reg;
   logic [7:0] low_byte_t0;
   logic [7:0] high_byte_t0;
   logic [7:0] low_byte_t1;
   logic [7:0] high_byte_t1;

   timer_mode_t mode_t0;
   timer_mode_t mode_t1;
   logic gate_sel_t0;
   logic gate_sel_t1;
   logic ct_sel_t0;
   logic ct_sel_t1;

   assign mode_t0 = timer_mode_t'(timer_mode_reg[MOD_SEL_T0 +: 2]);
   assign mode_t1 = timer_mode_t'(timer_mode_reg[MOD_SEL_T1 +: 2]);
   assign gate_sel_t0 = timer_mode_reg[MOD_GATE_T0];
   assign gate_sel_t1 = timer_mode_reg[MOD_GATE_T1];
   assign ct_sel_t0 = timer_mode_reg[MOD_CT_T0];
   assign ct_sel_t1 = timer_mode_reg[MOD_CT_T1];

   // Count enables.
   logic src_t0;
   logic src_t1;
   logic inc_t0;
   logic inc_t1;
   logic inc_high_split;

   assign src_t0 = ct_sel_t0 ? mc.count_fall[0] : mc.tick;
   assign src_t1 = ct_sel_t1 ? mc.count_fall[1] : mc.tick;
   assign inc_t0 = src_t0 & run_bit_t0 &
                   (~gate_sel_t0 | gate_pin_t0_in);
   // Timer 1 in mode 3 is starved of increments, so its bytes simply hold.
   assign inc_t1 = src_t1 & run_bit_t1 & (mode_t1 != MODE_SPLIT) &
                   (~gate_sel_t1 | gate_pin_t1_in);
   // The split high byte ignores timer 0's gate and select bits and follows
   // timer 1's run bit alone.
   assign inc_high_split = mc.tick & run_bit_t1 &
                           (mode_t0 == MODE_SPLIT);

   // Next count of one timer in modes 0 to 2; bit 16 is the overflow.
   function automatic logic [16:0] step(input timer_mode_t m,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [16:0] r;
      logic [5:0] pre;
      logic [8:0] h9;
      logic [16:0] w;
      logic [8:0] l9;
      r = {1'b0, hi, lo};
      case (m)
         MODE_13BIT: begin
            // Upper three low-byte bits are untouched and carry no meaning.
            pre = {1'b0, lo[PRESCALE_BITS-1:0]} + 6'h01;
            h9 = {1'b0, hi} + {8'h00, pre[PRESCALE_BITS]};
            r = {h9[8], h9[7:0], lo[7:5], pre[4:0]};
         end
         MODE_16BIT: begin
            w = {1'b0, hi, lo} + 17'h00001;
            r = w;
         end
         MODE_RELOAD: begin
            l9 = {1'b0, lo} + 9'h001;
            if (l9[8]) begin
               r = {1'b1, hi, hi};
            end else begin
               r = {1'b0, hi, l9[7:0]};
            end
         end
         default: begin
            r = {1'b0, hi, lo};
         end
      endcase
      return r;
   endfunction

   logic [16:0] next_t0;
   logic [16:0] next_t1;
   logic [8:0] next_low_split;
   logic [8:0] next_high_split;
   logic ovf_t0;
   logic ovf_t1;
   logic ovf_high_split;

   // Both timers share one step, each fed with its own mode and bytes.
   assign next_t0 = step(mode_t0, high_byte_t0, low_byte_t0);
   assign next_t1 = step(mode_t1, high_byte_t1, low_byte_t1);
   assign next_low_split = {1'b0, low_byte_t0} + 9'h001;
   assign next_high_split = {1'b0, high_byte_t0} + 9'h001;

   // Overflows exist only in a cycle with an increment, so every hardware flag set
   // lands on a machine-cycle tick.
   assign ovf_t0 = inc_t0 & ((mode_t0 == MODE_SPLIT) ?
                   next_low_split[8] : next_t0[16]);
   assign ovf_t1 = inc_t1 & next_t1[16];
   assign ovf_high_split = inc_high_split & next_high_split[8];

   logic wr_ctl;
   logic wr_mode;
   logic wr_low_t0;
   logic wr_high_t0;
   logic wr_low_t1;
   logic wr_high_t1;

   // Each strobe selects exactly one register; offsets 6 and 7 match none,
   // so writes there are ignored.
   assign wr_ctl = wr_in & (addr_in == OFS_CONTROL);
   assign wr_mode = wr_in & (addr_in == OFS_MODE);
   assign wr_low_t0 = wr_in & (addr_in == OFS_LOW_T0);
   assign wr_high_t0 = wr_in & (addr_in == OFS_HIGH_T0);
   assign wr_low_t1 = wr_in & (addr_in == OFS_LOW_T1);
   assign wr_high_t1 = wr_in & (addr_in == OFS_HIGH_T1);

   // Run bits, software only; starting a timer does not touch its count.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_bit_t0 <= RST_CONTROL[CTL_RUN_T0];
         run_bit_t1 <= RST_CONTROL[CTL_RUN_T1];
      end else if (wr_ctl) begin
         run_bit_t0 <= wdata_in[CTL_RUN_T0];
         run_bit_t1 <= wdata_in[CTL_RUN_T1];
      end
   end

   // Overflow flags: a hardware set beats a write or vector clear in the
   // same cycle.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflow_flag_t0 <= RST_CONTROL[CTL_FLAG_T0];
      end else if (ovf_t0) begin
         overflow_flag_t0 <= 1'b1;
      end else if (vector_ack_t0_in) begin
         overflow_flag_t0 <= 1'b0;
      end else if (wr_ctl) begin
         overflow_flag_t0 <= wdata_in[CTL_FLAG_T0];
      end
   end

   // Timer 1's flag belongs to timer 0's high byte while timer 0 is split.
   logic set_flag_t1;
   assign set_flag_t1 = (mode_t0 == MODE_SPLIT) ? ovf_high_split : ovf_t1;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflow_flag_t1 <= RST_CONTROL[CTL_FLAG_T1];
      end else if (set_flag_t1) begin
         overflow_flag_t1 <= 1'b1;
      end else if (vector_ack_t1_in) begin
         overflow_flag_t1 <= 1'b0;
      end else if (wr_ctl) begin
         overflow_flag_t1 <= wdata_in[CTL_FLAG_T1];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_mode_reg <= RST_MODE;
      end else if (wr_mode) begin
         // A new mode applies from the next count; the bytes keep their value.
         timer_mode_reg <= wdata_in;
      end
   end

   // Timer 0 count bytes; a software write beats a count in the same cycle.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_byte_t0 <= RST_BYTE;
      end else if (wr_low_t0) begin
         low_byte_t0 <= wdata_in;
      end else if (inc_t0) begin
         if (mode_t0 == MODE_SPLIT) begin
            low_byte_t0 <= next_low_split[7:0];
         end else begin
            low_byte_t0 <= next_t0[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_byte_t0 <= RST_BYTE;
      end else if (wr_high_t0) begin
         high_byte_t0 <= wdata_in;
      end else if (mode_t0 == MODE_SPLIT) begin
         // Timer 1's run bit, not timer 0's, advances this byte.
         if (inc_high_split) begin
            high_byte_t0 <= next_high_split[7:0];
         end
      end else if (inc_t0) begin
         high_byte_t0 <= next_t0[15:8];
      end
   end

   // Timer 1 count bytes; no increment reaches them while held in mode 3.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_byte_t1 <= RST_BYTE;
      end else if (wr_low_t1) begin
         low_byte_t1 <= wdata_in;
      end else if (inc_t1) begin
         low_byte_t1 <= next_t1[7:0];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_byte_t1 <= RST_BYTE;
      end else if (wr_high_t1) begin
         high_byte_t1 <= wdata_in;
      end else if (inc_t1) begin
         high_byte_t1 <= next_t1[15:8];
      end
   end

   // Baud-rate overflow event of timer 1, available in every timer 0 mode.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflow_pulse_t1_out <= 1'b0;
      end else begin
         overflow_pulse_t1_out <= ovf_t1;
      end
   end

   // Control register as software sees it; bits 3 to 0 always read 0.
   logic [7:0] control_view;

   always_comb begin
      control_view = 8'h00;
      control_view[CTL_RUN_T0] = run_bit_t0;
      control_view[CTL_FLAG_T0] = overflow_flag_t0;
      control_view[CTL_RUN_T1] = run_bit_t1;
      control_view[CTL_FLAG_T1] = overflow_flag_t1;
   end

   // Read data stand for the single cycle after the read strobe.
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            OFS_CONTROL: begin
               next_rdata = control_view;
            end
            OFS_MODE: begin
               next_rdata = timer_mode_reg;
            end
            OFS_LOW_T0: begin
               next_rdata = low_byte_t0;
            end
            OFS_HIGH_T0: begin
               next_rdata = high_byte_t0;
            end
            OFS_LOW_T1: begin
               next_rdata = low_byte_t1;
            end
            OFS_HIGH_T1: begin
               next_rdata = high_byte_t1;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= next_rdata;
      end
   end

   assign overflow_flag_t0_out = overflow_flag_t0;
   assign overflow_flag_t1_out = overflow_flag_t1;

endmodule

// >>> rtl/mcycle_gen.sv
`timescale 1ns/1ps
module mcycle_gen
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Machine-cycle strobe.
   mcycle_if.gen mc
);

   logic [3:0] phase;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= 4'h0;
      end else if (phase == MCYCLE_LAST) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end

   assign mc.tick = (phase == MCYCLE_LAST);

endmodule

// >>> rtl/pin_sampler.sv
`timescale 1ns/1ps
module pin_sampler
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // External count pins, bit 0 for timer 0.
   input wire logic [1:0] count_pin_in,
   // Strobe in, falling-edge events out.
   mcycle_if.sampler mc
);

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pin
         logic sample;
         logic fall;

         // The pin is sampled once per machine cycle; a high sample followed
         // by a low one yields one count event in the next machine cycle.
         always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sample <= 1'b0;
               fall <= 1'b0;
            end else if (mc.tick) begin
               sample <= count_pin_in[i];
               fall <= sample & ~count_pin_in[i];
            end
         end

         assign mc.count_fall[i] = fall & mc.tick;
      end
   endgenerate

endmodule

// >>> tb/dual_timer_monitor.sv
`timescale 1ns/1ps
module dual_timer_monitor
   import timer_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   // Acknowledges, flags and pulse.
   input wire logic vector_ack_t0_in,
   input wire logic vector_ack_t1_in,
   input wire logic overflow_flag_t0_out,
   input wire logic overflow_flag_t1_out,
   input wire logic overflow_pulse_t1_out
);
   logic [3:0] phase;
   logic ctl_wr;

   // Mirrors the machine-cycle phase, which restarts with every reset.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= 4'h0;
      end else begin
         phase <= (phase == MCYCLE_LAST) ? 4'h0 : phase + 4'h1;
      end
   end

   assign ctl_wr = wr_in && addr_in == OFS_CONTROL;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside a read cycle");
   chk_unmapped_zero: assert property
      ($past(rd_in && addr_in > OFS_HIGH_T1) |-> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chk_mode_readback: assert property (
      rd_in && addr_in == OFS_MODE && $past(wr_in && addr_in == OFS_MODE, 2)
      |=> rdata_out == $past(wdata_in, 3))
      else $error("mode register readback wrong");
   chk_flag0_rise: assert property ($rose(overflow_flag_t0_out) |->
      $past(phase) == MCYCLE_LAST || $past(ctl_wr && wdata_in[CTL_FLAG_T0]))
      else $error("flag 0 set off a machine-cycle tick");
   chk_flag1_rise: assert property ($rose(overflow_flag_t1_out) |->
      $past(phase) == MCYCLE_LAST || $past(ctl_wr && wdata_in[CTL_FLAG_T1]))
      else $error("flag 1 set off a machine-cycle tick");
   chk_flag0_fall: assert property ($fell(overflow_flag_t0_out) |->
      $past(vector_ack_t0_in) || $past(ctl_wr && !wdata_in[CTL_FLAG_T0]))
      else $error("flag 0 cleared without cause");
   chk_ack_clear0: assert property (
      vector_ack_t0_in && phase != MCYCLE_LAST && !ctl_wr
      |=> !overflow_flag_t0_out)
      else $error("acknowledge left flag 0 set");
   chk_pulse_phase: assert property (overflow_pulse_t1_out |->
      phase == 4'h0 ##1 !overflow_pulse_t1_out [*8])
      else $error("overflow pulse misplaced");

   cover property ($rose(overflow_flag_t0_out));
   cover property (overflow_pulse_t1_out);
   cover property (vector_ack_t1_in && overflow_flag_t1_out);
endmodule

bind dual_timer dual_timer_monitor mon (.ref_clk_in, .rst_n_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .rdata_out, .vector_ack_t0_in,
   .vector_ack_t1_in, .overflow_flag_t0_out, .overflow_flag_t1_out,
   .overflow_pulse_t1_out);

// >>> tb/pin_source.sv
`timescale 1ns/1ps
module pin_source #(
   parameter int HALF = 12
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Enable from the bench.
   input wire logic en_in,
   // Count pin toward the timer.
   output logic pin_out
);
   int cnt;

   // Each level lasts HALF clocks, never less than one machine cycle.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in || !en_in) begin
         cnt <= 0;
         pin_out <= 1'b1;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         pin_out <= !pin_out;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import timer_pkg::*;
   typedef struct packed {
      logic t1;
      logic [7:0] mode, lo, hi;
      logic [3:0] n;
      logic [7:0] elo, ehi;
      logic eflag;
   } row_t;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0, rd_in = 1'b0, en0 = 1'b0, en1 = 1'b0;
   logic gate_pin_t0_in = 1'b0, gate_pin_t1_in = 1'b0;
   logic vector_ack_t0_in = 1'b0, vector_ack_t1_in = 1'b0;
   logic count_pin_t0_in, count_pin_t1_in;
   logic overflow_flag_t0_out, overflow_flag_t1_out, overflow_pulse_t1_out;
   logic [7:0] rdata_out, d;
   logic [2:0] seen = 3'h0;
   int error_cnt = 0, tests_run = 0;
   row_t rows [9] = '{
      '{1'b0, 8'h00, 8'h1e, 8'h00, 4'h3, 8'h01, 8'h01, 1'b0},
      '{1'b0, 8'h00, 8'h1f, 8'hff, 4'h1, 8'h00, 8'h00, 1'b1},
      '{1'b0, 8'h01, 8'hfe, 8'h00, 4'h3, 8'h01, 8'h01, 1'b0},
      '{1'b0, 8'h02, 8'hfe, 8'h80, 4'h3, 8'h81, 8'h80, 1'b1},
      '{1'b1, 8'h00, 8'h1f, 8'hff, 4'h1, 8'h00, 8'h00, 1'b1},
      '{1'b1, 8'h20, 8'hff, 8'hf0, 4'h2, 8'hf1, 8'hf0, 1'b1},
      '{1'b1, 8'h30, 8'h12, 8'h34, 4'h5, 8'h12, 8'h34, 1'b0},
      '{1'b0, 8'h03, 8'hfe, 8'h00, 4'h3, 8'h01, 8'h00, 1'b1},
      '{1'b0, 8'h09, 8'h10, 8'h00, 4'h4, 8'h10, 8'h00, 1'b0}
   };

   always #2 ref_clk_in = ~ref_clk_in;
   always @(negedge ref_clk_in) seen = seen |
      {overflow_pulse_t1_out, overflow_flag_t1_out, overflow_flag_t0_out};

   dual_timer DUT (.ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .count_pin_t0_in, .count_pin_t1_in,
      .gate_pin_t0_in, .gate_pin_t1_in, .vector_ack_t0_in,
      .vector_ack_t1_in, .overflow_flag_t0_out, .overflow_flag_t1_out,
      .overflow_pulse_t1_out);
   pin_source #(.HALF(12)) src0 (.ref_clk_in, .rst_n_in, .en_in(en0),
      .pin_out(count_pin_t0_in));
   pin_source #(.HALF(30)) src1 (.ref_clk_in, .rst_n_in, .en_in(en1),
      .pin_out(count_pin_t1_in));

   task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(negedge ref_clk_in);
      v = rdata_out;
      @(posedge ref_clk_in);
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Runs for exactly n machine cycles, then stops both timers.
   task automatic run_n(input logic [7:0] c, input int n);
      seen = 3'h0;
      bus_wr(OFS_CONTROL, c);
      repeat (12 * n - 2) @(posedge ref_clk_in);
      bus_wr(OFS_CONTROL, 8'h00);
   endtask
   task automatic run_row(input row_t r);
      logic [2:0] a;
      logic [7:0] m;
      a = r.t1 ? OFS_LOW_T1 : OFS_LOW_T0;
      m = ((r.t1 ? r.mode[5:4] : r.mode[1:0]) == 2'h0) ? 8'h1f : 8'hff;
      bus_wr(OFS_CONTROL, 8'h00);
      bus_wr(OFS_MODE, r.mode);
      bus_wr(a, r.lo);
      bus_wr(a + 3'h1, r.hi);
      run_n(r.t1 ? 8'h40 : 8'h10, r.n);
      bus_rd(a, d);
      check(d & m, r.elo & m);
      bus_rd(a + 3'h1, d);
      check(d, r.ehi);
      check({7'h0, seen[r.t1]}, {7'h0, r.eflag});
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #80000;
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      foreach (rows[i]) run_row(rows[i]);
      gate_pin_t0_in <= 1'b1;
      run_row('{1'b0, 8'h09, 8'h00, 8'h00, 4'h2, 8'h02, 8'h00, 1'b0});
      bus_wr(OFS_MODE, 8'hc6);
      bus_rd(OFS_MODE, d);
      check(d, 8'hc6);
      bus_wr(OFS_CONTROL, 8'h0f);
      bus_rd(OFS_CONTROL, d);
      check(d, 8'h00);
      bus_rd(3'h6, d);
      check(d, 8'h00);
      bus_wr(OFS_CONTROL, 8'ha0);
      check({6'h0, overflow_flag_t1_out, overflow_flag_t0_out}, 8'h03);
      vector_ack_t0_in <= 1'b1;
      vector_ack_t1_in <= 1'b1;
      @(posedge ref_clk_in);
      vector_ack_t0_in <= 1'b0;
      vector_ack_t1_in <= 1'b0;
      @(negedge ref_clk_in);
      check({6'h0, overflow_flag_t1_out, overflow_flag_t0_out}, 8'h00);
      @(posedge ref_clk_in);
      bus_wr(OFS_MODE, 8'h55);
      for (int a = 2; a < 6; a++) bus_wr(3'(a), 8'h00);
      bus_wr(OFS_CONTROL, 8'h50);
      en0 <= 1'b1;
      en1 <= 1'b1;
      repeat (72) @(posedge ref_clk_in);
      en0 <= 1'b0;
      repeat (48) @(posedge ref_clk_in);
      en1 <= 1'b0;
      repeat (36) @(posedge ref_clk_in);
      bus_wr(OFS_CONTROL, 8'h00);
      bus_rd(OFS_LOW_T0, d);
      check(d, 8'h03);
      bus_rd(OFS_LOW_T1, d);
      check(d, 8'h02);
      bus_wr(OFS_MODE, 8'h13);
      for (int a = 2; a < 6; a++) bus_wr(3'(a), (a == 2) ? 8'h00 : 8'hff);
      run_n(8'h40, 1);
      bus_rd(OFS_HIGH_T0, d);
      check(d, 8'h00);
      bus_rd(OFS_LOW_T1, d);
      check(d, 8'h00);
      check({5'h0, seen}, 8'h06);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      for (int a = 0; a < 8; a++) begin
         bus_rd(3'(a), d);
         check(d, 8'h00);
      end
      print_verdict();
   end
endmodule
